// ==== uart_pkg.sv ====
// Constants shared by the serial port design
package uart_pkg;
   // ***************************************************
   // Register addresses
   // ***************************************************
   localparam logic [7:0] addr_serial_control = 8'h98;
   localparam logic [7:0] addr_serial_data = 8'h99;
   localparam logic [7:0] addr_baud_ctrl = 8'h9a;
   localparam logic [7:0] addr_baud_reload = 8'h9b;
   // ***************************************************
   // Control register bit positions
   // ***************************************************
   localparam int bit_frame_mode = 7;
   localparam int bit_unused_one = 6;
   localparam int bit_multiproc = 5;
   localparam int bit_rx_enable = 4;
   localparam int bit_tx_ninth = 3;
   localparam int bit_rx_ninth = 2;
   localparam int bit_tx_done = 1;
   localparam int bit_rx_done = 0;
   localparam int bit_timer_run = 0;
   localparam int bit_irq_enable = 1;
   // ***************************************************
   // Reset values and counts
   // ***************************************************
   localparam logic [7:0] reset_byte = 8'h00;
   localparam logic [7:0] counter_top = 8'hff;
   localparam logic [2:0] last_data_bit = 3'h7;
   // Bit-sequence states shared by both directions
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_start = 3'b001,
      st_data = 3'b010,
      st_ninth = 3'b011,
      st_stop = 3'b100
   } frame_state_e;
endpackage : uart_pkg

// ==== uart_timer_baud_multiproc.sv ====
// Serial port with timer baud generation and ninth-bit address filter
// How it works
// - Data writes load transmitter; reads return receive buffer
// - Completed byte buffered apart from receive shifter
// - Done flags cleared only by software write
// - Interrupt raised when enabled and flag set
// - Transmit counter and hidden receive counter copy
// - Counter overflows divided by two per bit
// - Receive copy runs with timer, same reload
// - Start detection forces receive counter reload
// - Frame mode bit sits at control bit seven
// - Mode zero eight-bit, mode one nine-bit
// - Eight-bit frame: start, eight LSB first, stop
// - Eight-bit accept stores data and stop bit
// - Writing data buffer starts a transmission
// - Transmit-done set at start of stop bit
// - Reception starts only while receive enable is one
// - Eight-bit accept needs flag clear, stop checked only with multiprocessor enable
// - Failed accept changes nothing, no flag
// - Overrun keeps first byte, drops later one
// - Nine-bit frame, ninth from transmit ninth bit
// - Nine-bit accept needs flag clear, ninth checked only with multiprocessor enable
// - Nine-bit accept stores ninth, ignores stop
`timescale 1ns/10ps
`default_nettype none
module uart_timer_baud_multiproc (
   // Clock and reset
   input wire logic clock_in,
   input wire logic reset_in,
   // Register port
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic write_in,
   input wire logic read_in,
   output logic [7:0] rdata_out,
   // Serial pins
   input wire logic serial_rx_pin_in,
   output logic serial_tx_pin_out,
   // Interrupt request
   output logic irq_out
);
   import uart_pkg::*;
   // ***************************************************
   // Registers and state
   // ***************************************************
   logic frame_mode_bit, multiproc_enable_bit, rx_enable_bit;
   logic tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag;
   logic [7:0] serial_data_buffer, baud_reload_byte;
   logic timer_run, irq_enable;
   logic [7:0] baud_counter_low, rx_counter;
   logic tx_phase, rx_phase;
   logic rx_meta, rx_sync, rx_prev;
   frame_state_e tx_state, rx_state;
   logic [7:0] tx_shift, tx_hold, rx_shift;
   logic [2:0] tx_index, rx_index;
   logic tx_pending, rx_ninth_sample;
   // Access decode used in several places
   function automatic logic hit(input logic strobe,
                                input logic [7:0] a,
                                input logic [7:0] target);
      hit = strobe && (a == target);
   endfunction : hit
   logic wr_ctrl, wr_data, rd_data;
   assign wr_ctrl = hit(write_in, addr_in, addr_serial_control);
   assign wr_data = hit(write_in, addr_in, addr_serial_data);
   assign rd_data = hit(read_in, addr_in, addr_serial_data);
   // ***************************************************
   // Baud generation
   // ***************************************************
   logic tx_overflow, rx_overflow, tx_bit_tick, rx_sample;
   logic start_detect, rx_fall;
   assign tx_overflow = timer_run && (baud_counter_low == counter_top);
   assign rx_overflow = timer_run && (rx_counter == counter_top);
   assign tx_bit_tick = tx_overflow && tx_phase;
   assign rx_sample = rx_overflow && !rx_phase;
   assign rx_fall = rx_prev && !rx_sync;
   // Idle receiver armed only when enabled and timer running
   assign start_detect = (rx_state == st_idle) && rx_enable_bit &&
                         timer_run && rx_fall;
   // Transmit counter, auto-reload from reload byte
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         baud_counter_low <= reset_byte;
         tx_phase <= 1'b0;
      end else if (tx_overflow) begin
         baud_counter_low <= baud_reload_byte;
         tx_phase <= !tx_phase;
      end else if (timer_run) begin
         baud_counter_low <= baud_counter_low + 8'h01;
      end
   end
   // Hidden receive copy; start edge realigns it
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         rx_counter <= reset_byte;
         rx_phase <= 1'b0;
      end else if (start_detect) begin
         rx_counter <= baud_reload_byte;
         rx_phase <= 1'b0;
      end else if (rx_overflow) begin
         rx_counter <= baud_reload_byte;
         rx_phase <= !rx_phase;
      end else if (timer_run) begin
         rx_counter <= rx_counter + 8'h01;
      end
   end
   // Pin synchroniser; the second stage and its delayed third-stage copy feed logic
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
         rx_prev <= 1'b1;
      end else begin
         rx_meta <= serial_rx_pin_in;
         rx_sync <= rx_meta;
         rx_prev <= rx_sync;
      end
   end
   // ***************************************************
   // Transmitter
   // ***************************************************
   // Frames only begin on a bit tick, so every bit is whole
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         tx_state <= st_idle;
         tx_shift <= reset_byte;
         tx_hold <= reset_byte;
         tx_index <= 3'h0;
         tx_pending <= 1'b0;
         serial_tx_pin_out <= 1'b1;
      end else begin
         if (wr_data) begin
            tx_hold <= wdata_in;
            tx_pending <= 1'b1;
         end
         if (tx_bit_tick) begin
            case (tx_state)
               st_idle: begin
                  if (tx_pending && !wr_data) begin
                     tx_state <= st_start;
                     tx_shift <= tx_hold;
                     tx_pending <= 1'b0;
                     serial_tx_pin_out <= 1'b0;
                  end
               end
               st_start: begin
                  tx_state <= st_data;
                  tx_index <= 3'h0;
                  serial_tx_pin_out <= tx_shift[0];
                  tx_shift <= {1'b0, tx_shift[7:1]};
               end
               st_data: begin
                  if (tx_index != last_data_bit) begin
                     tx_index <= tx_index + 3'h1;
                     serial_tx_pin_out <= tx_shift[0];
                     tx_shift <= {1'b0, tx_shift[7:1]};
                  end else if (frame_mode_bit) begin
                     tx_state <= st_ninth;
                     serial_tx_pin_out <= tx_ninth_bit;
                  end else begin
                     tx_state <= st_stop;
                     serial_tx_pin_out <= 1'b1;
                  end
               end
               st_ninth: begin
                  tx_state <= st_stop;
                  serial_tx_pin_out <= 1'b1;
               end
               default: begin
                  tx_state <= st_idle;
                  serial_tx_pin_out <= 1'b1;
               end
            endcase
         end
      end
   end
   // Stop bit begins this cycle
   logic tx_stop_begin;
   assign tx_stop_begin = tx_bit_tick &&
      ((tx_state == st_ninth) ||
       ((tx_state == st_data) && (tx_index == last_data_bit) &&
        !frame_mode_bit));
   // ***************************************************
   // Receiver
   // ***************************************************
   logic rx_finish, rx_accept, rx_check_bit;
   assign rx_finish = rx_sample && (rx_state == st_stop);
   // Stop bit in eight-bit mode, ninth bit in nine-bit mode
   assign rx_check_bit = frame_mode_bit ? rx_ninth_sample : rx_sync;
   assign rx_accept = rx_finish && !rx_done_flag &&
      (!multiproc_enable_bit || rx_check_bit);
   // Shifter separate from buffer so a new byte may arrive
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         rx_state <= st_idle;
         rx_shift <= reset_byte;
         rx_index <= 3'h0;
         rx_ninth_sample <= 1'b0;
      end else if (start_detect) begin
         rx_state <= st_start;
      end else if (rx_sample) begin
         case (rx_state)
            st_start: begin
               // A glitch shorter than half a bit is dropped
               rx_state <= rx_sync ? st_idle : st_data;
               rx_index <= 3'h0;
            end
            st_data: begin
               rx_shift <= {rx_sync, rx_shift[7:1]};
               if (rx_index == last_data_bit) begin
                  rx_state <= frame_mode_bit ? st_ninth : st_stop;
               end else begin
                  rx_index <= rx_index + 3'h1;
               end
            end
            st_ninth: begin
               rx_ninth_sample <= rx_sync;
               rx_state <= st_stop;
            end
            default: begin
               rx_state <= st_idle;
            end
         endcase
      end
   end
   // Receive buffer and ninth bit; refused frames leave them
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         serial_data_buffer <= reset_byte;
         rx_ninth_bit <= 1'b0;
      end else if (rx_accept) begin
         serial_data_buffer <= rx_shift;
         rx_ninth_bit <= rx_check_bit;
      end else if (wr_ctrl) begin
         rx_ninth_bit <= wdata_in[bit_rx_ninth];
      end
   end
   // ***************************************************
   // Control register and flags
   // ***************************************************
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         frame_mode_bit <= 1'b0;
         multiproc_enable_bit <= 1'b0;
         rx_enable_bit <= 1'b0;
         tx_ninth_bit <= 1'b0;
      end else if (wr_ctrl) begin
         frame_mode_bit <= wdata_in[bit_frame_mode];
         multiproc_enable_bit <= wdata_in[bit_multiproc];
         rx_enable_bit <= wdata_in[bit_rx_enable];
         tx_ninth_bit <= wdata_in[bit_tx_ninth];
      end
   end
   // Hardware set beats a software clear in the same cycle
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         tx_done_flag <= 1'b0;
         rx_done_flag <= 1'b0;
      end else begin
         if (tx_stop_begin) begin
            tx_done_flag <= 1'b1;
         end else if (wr_ctrl) begin
            tx_done_flag <= wdata_in[bit_tx_done];
         end
         if (rx_accept) begin
            rx_done_flag <= 1'b1;
         end else if (wr_ctrl) begin
            rx_done_flag <= wdata_in[bit_rx_done];
         end
      end
   end
   // Baud timer control and reload byte
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         timer_run <= 1'b0;
         irq_enable <= 1'b0;
         baud_reload_byte <= reset_byte;
      end else begin
         if (hit(write_in, addr_in, addr_baud_ctrl)) begin
            timer_run <= wdata_in[bit_timer_run];
            irq_enable <= wdata_in[bit_irq_enable];
         end
         if (hit(write_in, addr_in, addr_baud_reload)) begin
            baud_reload_byte <= wdata_in;
         end
      end
   end
   // Level request, no event can slip past the enable
   assign irq_out = irq_enable && (tx_done_flag || rx_done_flag);
   // ***************************************************
   // Read port, data one cycle after the strobe
   // ***************************************************
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         rdata_out <= reset_byte;
      end else if (!read_in) begin
         rdata_out <= reset_byte;
      end else if (addr_in == addr_serial_control) begin
         rdata_out <= {frame_mode_bit, 1'b1, multiproc_enable_bit,
                       rx_enable_bit, tx_ninth_bit, rx_ninth_bit,
                       tx_done_flag, rx_done_flag};
      end else if (addr_in == addr_serial_data) begin
         rdata_out <= serial_data_buffer;
      end else if (addr_in == addr_baud_ctrl) begin
         rdata_out <= {6'h00, irq_enable, timer_run};
      end else if (addr_in == addr_baud_reload) begin
         rdata_out <= baud_reload_byte;
      end else begin
         rdata_out <= reset_byte;
      end
   end
   // ***************************************************
   // Assertions
   // ***************************************************
   a_data_read_path: assert property (
      @(posedge clock_in) disable iff (reset_in)
      rd_data |=> rdata_out == $past(serial_data_buffer))
      else $error("data read did not return receive buffer");
   a_flag_hold: assert property (
      @(posedge clock_in) disable iff (reset_in)
      rx_done_flag && !wr_ctrl |=> rx_done_flag)
      else $error("receive flag cleared without a write");
   a_irq_on_flag: assert property (
      @(posedge clock_in) disable iff (reset_in)
      $rose(tx_done_flag) && irq_enable |-> irq_out)
      else $error("no interrupt on transmit done");
   a_tick_halved: assert property (
      @(posedge clock_in) disable iff (reset_in)
      tx_bit_tick |=> !tx_phase ##0 !tx_bit_tick)
      else $error("bit tick not every second overflow");
   a_start_reload: assert property (
      @(posedge clock_in) disable iff (reset_in)
      start_detect |=> rx_counter == $past(baud_reload_byte)
         && !rx_phase && rx_state == st_start)
      else $error("start did not reload receive counter");
   a_stop_sets_done: assert property (
      @(posedge clock_in) disable iff (reset_in)
      tx_stop_begin |=> tx_done_flag && tx_state == st_stop
         && serial_tx_pin_out)
      else $error("transmit done not set at stop bit");
   a_rx_disabled: assert property (
      @(posedge clock_in) disable iff (reset_in)
      rx_state == st_idle && !rx_enable_bit |=> rx_state == st_idle)
      else $error("receiver started while disabled");
   a_overrun_keep: assert property (
      @(posedge clock_in) disable iff (reset_in)
      rx_done_flag ##1 rx_done_flag |-> $stable(serial_data_buffer))
      else $error("buffer overwritten during overrun");
   a_ninth_store: assert property (
      @(posedge clock_in) disable iff (reset_in)
      rx_accept && frame_mode_bit |=>
         rx_ninth_bit == $past(rx_ninth_sample) && rx_done_flag)
      else $error("ninth bit not stored on accept");
   a_refused_quiet: assert property (
      @(posedge clock_in) disable iff (reset_in)
      rx_finish && multiproc_enable_bit && !rx_check_bit
         && !wr_ctrl |=> $stable(serial_data_buffer)
         && $stable(rx_done_flag))
      else $error("refused frame changed receive state");
endmodule : uart_timer_baud_multiproc
`default_nettype wire

// ==== uart_far_end.sv ====
// Behavioural remote serial transceiver facing the port's pins
`timescale 1ns/10ps
`default_nettype none
module uart_far_end #(
   parameter int bit_clks = 8
) (
   // Clock and frame mode
   input wire logic clock_in,
   input wire logic nine_bit_in,
   // Serial lines
   input wire logic line_from_dut_in,
   output logic line_to_dut_out
);
   // ***************************************************
   // Captured frame
   // ***************************************************
   logic [7:0] got_data;
   logic got_ninth;
   logic got_stop;
   int n_frames = 0;

   // Line idles high, as with a pull-up
   initial line_to_dut_out = 1'b1;

   // One frame, LSB first; ninth bit only in nine-bit frames
   task automatic send_frame(input logic [7:0] data, input logic ninth,
                             input logic stop);
      logic [10:0] bits;
      int n;
      n = nine_bit_in ? 11 : 10;
      bits = nine_bit_in ? {stop, ninth, data, 1'b0} :
                           {1'b1, stop, data, 1'b0};
      @(posedge clock_in);
      for (int i = 0; i < n; i++) begin
         line_to_dut_out <= bits[i];
         repeat (bit_clks) @(posedge clock_in);
      end
      // A low stop bit must not leave the line low afterwards
      line_to_dut_out <= 1'b1;
      repeat (bit_clks) @(posedge clock_in);
   endtask : send_frame

   // Mid-bit sampling keeps clear of the port's own bit edges
   always begin
      @(negedge line_from_dut_in);
      repeat (bit_clks / 2) @(posedge clock_in);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_clks) @(posedge clock_in);
         got_data[i] = line_from_dut_in;
      end
      got_ninth = 1'b0;
      if (nine_bit_in) begin
         repeat (bit_clks) @(posedge clock_in);
         got_ninth = line_from_dut_in;
      end
      repeat (bit_clks) @(posedge clock_in);
      got_stop = line_from_dut_in;
      n_frames++;
   end
endmodule : uart_far_end
`default_nettype wire

// ==== tb.sv ====
// Self-checking testbench for the serial port
`timescale 1ns/10ps
`default_nettype none
module tb;
   import uart_pkg::*;
   // ***************************************************
   // Settings and signals
   // ***************************************************
   localparam logic [7:0] reload = 8'hfc;
   localparam int bit_clks = 2 * (256 - int'(reload));
   logic clock_in = 1'b0;
   logic reset_in = 1'b1;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic write_in = 1'b0;
   logic read_in = 1'b0;
   logic [7:0] rdata_out;
   logic serial_rx_pin;
   logic serial_tx_pin;
   logic irq_out;
   logic nine_bit = 1'b0;
   logic [7:0] d;
   int n_mismatch = 0;
   int n_checks = 0;

   // 25 MHz clock
   initial begin
      forever #20 clock_in = ~clock_in;
   end

   uart_timer_baud_multiproc DUT (
      .clock_in(clock_in),
      .reset_in(reset_in),
      .addr_in(addr_in),
      .wdata_in(wdata_in),
      .write_in(write_in),
      .read_in(read_in),
      .rdata_out(rdata_out),
      .serial_rx_pin_in(serial_rx_pin),
      .serial_tx_pin_out(serial_tx_pin),
      .irq_out(irq_out)
   );

   uart_far_end #(.bit_clks(bit_clks)) far (
      .clock_in(clock_in),
      .nine_bit_in(nine_bit),
      .line_from_dut_in(serial_tx_pin),
      .line_to_dut_out(serial_rx_pin)
   );

   // ***************************************************
   // Bus and compare tasks
   // ***************************************************
   task automatic report_and_stop();
      $display("mismatches %0d checks %0d", n_mismatch, n_checks);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk8

   // Waiting for an edge first keeps strobes from being set twice at once
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= v;
      write_in <= 1'b1;
      @(posedge clock_in);
      write_in <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clock_in);
      addr_in <= a;
      read_in <= 1'b1;
      @(posedge clock_in);
      read_in <= 1'b0;
      #1 v = rdata_out;
   endtask : rd

   // Bounded wait for the far end to finish n frames; the first frame
   // also waits out the baud counter's first climb up from zero
   task automatic wait_frames(input int n);
      int limit;
      limit = 2 * 256 + 40 * bit_clks;
      for (int i = 0; i < limit && far.n_frames < n; i++) begin
         @(posedge clock_in);
      end
      chk8(8'(far.n_frames), 8'(n), "frame count");
   endtask : wait_frames

   // Bounded poll of the receive-done flag
   task automatic poll_rx();
      logic [7:0] c;
      c = 8'h00;
      for (int i = 0; i < 16 && c[bit_rx_done] !== 1'b1; i++) begin
         rd(addr_serial_control, c);
      end
      chk8({7'h00, c[bit_rx_done]}, 8'h01, "receive done");
   endtask : poll_rx

   task automatic settle();
      repeat (bit_clks) @(posedge clock_in);
   endtask : settle

   // ***************************************************
   // Scenarios
   // ***************************************************
   initial begin
      repeat (3) @(posedge clock_in);
      reset_in <= 1'b0;
      rd(addr_serial_control, d); chk8(d, 8'h40, "ctrl reset");
      rd(8'h00, d); chk8(d, 8'h00, "unmapped");
      wr(addr_baud_reload, reload);
      wr(addr_baud_ctrl, 8'h01);
      wr(addr_serial_control, 8'h10);
      // Eight-bit transmit, then done flag and interrupt
      wr(addr_serial_data, 8'ha5);
      wait_frames(1);
      chk8(far.got_data, 8'ha5, "tx data");
      chk8({7'h00, far.got_stop}, 8'h01, "tx stop");
      rd(addr_serial_control, d); chk8(d, 8'h52, "tx done");
      chk8({7'h00, irq_out}, 8'h00, "irq off");
      wr(addr_baud_ctrl, 8'h03);
      chk8({7'h00, irq_out}, 8'h01, "irq on");
      wr(addr_serial_control, 8'h10);
      chk8({7'h00, irq_out}, 8'h00, "irq cleared");
      // Eight-bit receive; transmit register not readable
      far.send_frame(8'h3c, 1'b0, 1'b1);
      poll_rx();
      rd(addr_serial_data, d); chk8(d, 8'h3c, "rx data");
      rd(addr_serial_control, d); chk8(d, 8'h55, "rx ninth");
      wr(addr_serial_data, 8'hc3);
      rd(addr_serial_data, d); chk8(d, 8'h3c, "no readback");
      wait_frames(2);
      chk8(far.got_data, 8'hc3, "tx second");
      // Overrun keeps first byte while next frame arrives
      far.send_frame(8'h55, 1'b0, 1'b1);
      settle();
      rd(addr_serial_data, d); chk8(d, 8'h3c, "overrun");
      // Stop check with multiprocessor enable, low stop refused
      wr(addr_serial_control, 8'h30);
      far.send_frame(8'h77, 1'b0, 1'b0);
      settle();
      rd(addr_serial_control, d); chk8(d, 8'h70, "stop refused");
      rd(addr_serial_data, d); chk8(d, 8'h3c, "buf kept");
      // Nine-bit transmit with ninth bit set
      nine_bit <= 1'b1;
      wr(addr_serial_control, 8'hb8);
      wr(addr_serial_data, 8'h81);
      wait_frames(3);
      chk8(far.got_data, 8'h81, "tx9 data");
      chk8({7'h00, far.got_ninth}, 8'h01, "tx9 ninth");
      // Nine-bit address filter: data refused, address taken
      wr(addr_serial_control, 8'hb8);
      far.send_frame(8'h12, 1'b0, 1'b1);
      settle();
      rd(addr_serial_control, d); chk8(d, 8'hf8, "ninth refused");
      far.send_frame(8'h34, 1'b1, 1'b0);
      poll_rx();
      rd(addr_serial_data, d); chk8(d, 8'h34, "addr data");
      rd(addr_serial_control, d); chk8(d, 8'hfd, "ninth kept");
      // Addressed slave drops the filter and takes data
      wr(addr_serial_control, 8'h98);
      far.send_frame(8'h56, 1'b0, 1'b1);
      poll_rx();
      rd(addr_serial_data, d); chk8(d, 8'h56, "data in");
      rd(addr_serial_control, d); chk8(d, 8'hd9, "ninth zero");
      // Receiver disabled ignores frames
      wr(addr_serial_control, 8'h80);
      far.send_frame(8'h99, 1'b0, 1'b1);
      settle();
      rd(addr_serial_control, d); chk8(d, 8'hc0, "rx off");
      report_and_stop();
   end

   // Overall limit cuts a hang short
   initial begin
      repeat (20000) @(posedge clock_in);
      n_mismatch++;
      $display("[ERR] %0t run limit reached", $time);
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
